// >>> dbh_pkg.sv
// Package with offsets, field positions and reset values for the host I/O decode
package dbh_pkg;
    // Register offsets from the board base (byte offsets on the host bus)
    localparam logic [7:0] OFF_BOARD_TYPE   = 8'h00;
    localparam logic [7:0] OFF_PRODUCT      = 8'h04;
    localparam logic [7:0] OFF_MAKER_HIGH   = 8'h10;
    localparam logic [7:0] OFF_MAKER_LOW    = 8'h14;
    localparam logic [7:0] OFF_CONFIG_LAST  = 8'h42;
    localparam logic [7:0] OFF_CTRL_STATUS  = 8'h40;
    localparam logic [7:0] OFF_BASE_ADDR    = 8'h48;
    localparam logic [7:0] OFF_PROC_CMD     = 8'h50;
    localparam logic [7:0] OFF_PTR_ACK      = 8'h52;
    localparam logic [7:0] OFF_SCSI_ADDR    = 8'h60;
    localparam logic [7:0] OFF_SCSI_CTRL    = 8'h62;
    localparam logic [7:0] OFF_DMA_STATE    = 8'h64;
    localparam logic [7:0] OFF_DMA_DATA     = 8'h68;
    // Control register bit positions
    localparam int BIT_INT_ENABLE   = 0;
    localparam int BIT_CTRL_SELECT  = 1;
    localparam int BIT_MASTER_RESET = 2;
    localparam int BIT_HOST_PTR     = 3;
    localparam int BIT_CTRL_PTR     = 3;
    localparam int BIT_INT_PENDING  = 4;
    localparam int BIT_INTERRUPT_FOLLOW_FLAG   = 7;
    // Low nybble expected with a process-command write
    localparam logic [3:0] PROC_CMD_TAG = 4'h1;
    // Values after reset
    localparam logic [7:0] BASE_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [15:0] PTR_RESET   = 16'h0000;
endpackage : dbh_pkg

// >>> dbh_pulse.sv
// One-cycle strobe generator from a raw decode hit
module dbh_pulse (
    input  wire logic clk_i,     // System clock
    input  wire logic rst_i,     // Synchronous reset
    input  wire logic hit_i,     // Decode hit this cycle
    output logic      pulse_o    // Registered one-cycle strobe
);
    // Register the strobe so it comes from a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= hit_i;
        end
    end
endmodule : dbh_pulse

// >>> dbh_config_rom.sv
// Auto-configuration identity nybble table
module dbh_config_rom #(
    parameter logic [7:0] BOARD_TYPE  = 8'hC1,  // Arbitrary value
    parameter logic [7:0] PRODUCT     = 8'h03,  // Arbitrary value
    parameter logic [7:0] MAKER_HIGH  = 8'h12,  // Arbitrary value
    parameter logic [7:0] MAKER_LOW   = 8'h34   // Arbitrary value
) (
    input  wire logic [7:0] offset_i,   // Byte offset from base
    output logic      [3:0] nybble_o    // Nybble for this location
);
    // High nybble at the first word, low nybble at the second
    function automatic logic [3:0] pick(input logic [7:0] v, input logic lo);
        pick = lo ? v[3:0] : v[7:4];
    endfunction : pick

    // Table lookup by offset group
    always_comb begin
        nybble_o = 4'h0;
        if (offset_i[7:2] == dbh_pkg::OFF_BOARD_TYPE[7:2]) begin
            nybble_o = pick(BOARD_TYPE, offset_i[1]);
        end else if (offset_i[7:2] == dbh_pkg::OFF_PRODUCT[7:2]) begin
            nybble_o = pick(PRODUCT, offset_i[1]);
        end else if (offset_i[7:2] == dbh_pkg::OFF_MAKER_HIGH[7:2]) begin
            nybble_o = pick(MAKER_HIGH, offset_i[1]);
        end else if (offset_i[7:2] == dbh_pkg::OFF_MAKER_LOW[7:2]) begin
            nybble_o = pick(MAKER_LOW, offset_i[1]);
        end
    end
endmodule : dbh_config_rom

// >>> dbh_host_io.sv
// Host I/O decode and control for the expansion disk board
// Access timing
// An access lasts one clock with sel_i high.
// Answer, read data and strobes come one clock later.
// Unconfigured: any upper address bits hit.
// Configured: top address byte must match the base.
//
// Control register layout
// Bit 0: interrupt enable, reads back.
// Bit 1: controller select, reads zero.
// Bit 2: onboard master reset, reads zero.
// Bit 3: host flag on write, controller flag on read.
// Bit 4: pending interrupt, read only.
// Bit 7: interrupt-follow status, read only.
//
// Hazards
// Onboard pulses may land in an access cycle.
// Raise beats acknowledge: no interrupt is lost.
// Set beats clear on the controller flag too.
// Trigger with a wrong low nybble is only acked.
// Offset 52 acknowledges in both directions.
// State before data is the host's duty.
// Offset 42 reads as an empty identity slot.
//
// Reset
// Every register clears; the board is unconfigured.
//
// Chip ports
// Selects and strobes stand for one clock.
// Chip read data is taken in the access cycle.
//
// Naming
// Names ending _q are state; hit names are decodes.
//
module dbh_host_io #(
    parameter int ADDR_W = 24   // Host address width
) (
    // Clock and reset
    input  wire logic              clk_i,              // System clock
    input  wire logic              rst_i,              // Synchronous reset
    // Host bus access
    input  wire logic [ADDR_W-1:0] addr_i,             // Host byte address
    input  wire logic [15:0]       wdata_i,            // Host write data
    input  wire logic              sel_i,              // One-cycle host access
    input  wire logic              we_i,               // High for write
    // Onboard controller events
    input  wire logic              ctrl_ptr_set_i,     // Onboard sets controller flag
    input  wire logic              ctrl_ptr_clr_i,     // Onboard clears controller flag
    input  wire logic              int_raise_i,        // Onboard raises interrupt
    input  wire logic              interrupt_follow_flag_i,       // Interrupt-follow status
    input  wire logic              config_done_i,      // Board configured
    // Chip read data
    input  wire logic [7:0]        scsi_rdata_i,       // Read data from SCSI chip
    input  wire logic [7:0]        dma_rdata_i,        // Read data from DMA chip
    // Host answer and board registers
    output logic      [15:0]       rdata_o,            // Host read data
    output logic                   ack_o,              // Access answered
    output logic      [7:0]        base_o,             // Board base address
    output logic                   int_enable_o,       // Interrupt enable
    output logic                   ctrl_select_o,      // High SCSI, low disk
    output logic                   master_reset_bit_o, // Onboard reset level
    output logic                   host_pointer_flag_o,      // Host handshake
    output logic                   interrupt_pending_flag_o, // Interrupt waiting
    output logic                   host_int_o,         // Interrupt to host
    // One-cycle strobes to the onboard side
    output logic                   process_command_trigger_o, // Start command
    output logic                   pointer_write_strobe_o,    // Pointer loaded
    output logic                   interrupt_acknowledge_o,   // Host acked
    output logic      [15:0]       cmd_ptr_o,          // Command block pointer
    // SCSI chip port
    output logic                   scsi_cs_o,          // SCSI chip select
    output logic                   scsi_a0_o,          // Low: address/status, high: control
    output logic                   scsi_we_o,          // SCSI write direction
    output logic      [7:0]        scsi_wdata_o,       // Data to SCSI chip
    // DMA chip port
    output logic                   dma_state_strobe_o, // DMA state strobe
    output logic                   dma_data_strobe_o,  // DMA data strobe
    output logic                   dma_we_o,           // DMA write direction
    output logic      [7:0]        dma_wdata_o         // Data to DMA chip
);
    // Offset inside the board window
    logic [7:0]  offset;            // Low address bits
    logic        in_board;          // Address hits this board
    logic        configured_q;      // Base written or config_done_i seen
    logic        controller_pointer_flag_q; // Onboard side of handshake
    // Decode hits, one per location
    logic        hit_proc;          // Valid trigger write
    logic        hit_ptr;           // Pointer or acknowledge
    logic        hit_scsi_addr;     // SCSI address/status
    logic        hit_scsi_ctrl;     // SCSI control window
    logic        hit_scsi;          // Either SCSI location
    logic        hit_dma_state;     // DMA state port
    logic        hit_dma_data;      // DMA data port
    logic        hit_dma;           // Either DMA port
    logic [3:0]  cfg_nybble;        // Identity nybble
    logic [7:0]  status_byte;       // Control read value

    // Offset match helper
    // Full byte compare: no aliasing
    function automatic logic at(input logic [7:0] off, input logic [7:0] target);
        at = (off == target);
    endfunction : at

    // Board window: before config the base is unused, after it upper bits match
    // Unconfigured board answers anywhere,
    // so setup can reach it before a base exists
    always_comb begin
        offset   = addr_i[7:0];
        in_board = sel_i && (!configured_q ||
                   (addr_i[ADDR_W-1:ADDR_W-8] == base_o));
    end

    // Decodes of board-unique strobe locations
    // All but hit_proc decode both directions alike;
    // users qualify with we_i where needed
    always_comb begin
        hit_proc      = in_board && we_i && at(offset, dbh_pkg::OFF_PROC_CMD)
                        && (wdata_i[3:0] == dbh_pkg::PROC_CMD_TAG);
        hit_ptr       = in_board && at(offset, dbh_pkg::OFF_PTR_ACK);
        hit_scsi_addr = in_board && at(offset, dbh_pkg::OFF_SCSI_ADDR);
        hit_scsi_ctrl = in_board && at(offset, dbh_pkg::OFF_SCSI_CTRL);
        hit_dma_state = in_board && at(offset, dbh_pkg::OFF_DMA_STATE);
        hit_dma_data  = in_board && at(offset, dbh_pkg::OFF_DMA_DATA);
        // Merged hits for several processes
        hit_scsi      = hit_scsi_addr || hit_scsi_ctrl;
        hit_dma       = hit_dma_state || hit_dma_data;
    end

    // Identity nybble table
    // Values are parameters of the table
    dbh_config_rom u_rom (
        .offset_i (offset),
        .nybble_o (cfg_nybble)
    );

    // Base address register, written by configuration
    // Base comes on the high data byte;
    // a later write at 48 moves the board
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_o       <= dbh_pkg::BASE_RESET;
            configured_q <= 1'b0;
        end else if (in_board && we_i && at(offset, dbh_pkg::OFF_BASE_ADDR)) begin
            base_o       <= wdata_i[15:8];
            configured_q <= 1'b1;
        end else if (config_done_i) begin
            // Configured without a base write
            configured_q <= 1'b1;
        end
    end

    // Control register write fields
    // Only the four defined bits are kept
    // Master reset is a level until rewritten
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_enable_o        <= dbh_pkg::CTRL_RESET[dbh_pkg::BIT_INT_ENABLE];
            ctrl_select_o       <= dbh_pkg::CTRL_RESET[dbh_pkg::BIT_CTRL_SELECT];
            master_reset_bit_o  <= dbh_pkg::CTRL_RESET[dbh_pkg::BIT_MASTER_RESET];
            host_pointer_flag_o <= dbh_pkg::CTRL_RESET[dbh_pkg::BIT_HOST_PTR];
        end else if (in_board && we_i && at(offset, dbh_pkg::OFF_CTRL_STATUS)) begin
            int_enable_o        <= wdata_i[8 + dbh_pkg::BIT_INT_ENABLE];
            ctrl_select_o       <= wdata_i[8 + dbh_pkg::BIT_CTRL_SELECT];
            master_reset_bit_o  <= wdata_i[8 + dbh_pkg::BIT_MASTER_RESET];
            host_pointer_flag_o <= wdata_i[8 + dbh_pkg::BIT_HOST_PTR];
        end
    end

    // Controller pointer flag, set wins over clear
    // Owned by the onboard side; host reads it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            controller_pointer_flag_q <= 1'b0;
        end else if (ctrl_ptr_set_i) begin
            controller_pointer_flag_q <= 1'b1;
        end else if (ctrl_ptr_clr_i) begin
            // Onboard has taken the pointer
            controller_pointer_flag_q <= 1'b0;
        end
    end

    // Pending interrupt: raise wins over acknowledge
    // A raise in the ack cycle keeps the flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            interrupt_pending_flag_o <= 1'b0;
        end else if (int_raise_i) begin
            interrupt_pending_flag_o <= 1'b1;
        end else if (hit_ptr) begin
            // Host acknowledge at 52
            interrupt_pending_flag_o <= 1'b0;
        end
    end

    // Gated interrupt toward the host
    // Lags enable and pending by one clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            host_int_o <= 1'b0;
        end else begin
            host_int_o <= int_enable_o && interrupt_pending_flag_o;
        end
    end

    // Command block pointer latch
    // Writes only; a read at 52 only acks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_ptr_o <= dbh_pkg::PTR_RESET;
        end else if (hit_ptr && we_i) begin
            cmd_ptr_o <= wdata_i;
        end
    end

    // One-cycle strobes
    // Registered hits: each stands one clock
    // Process-command trigger
    dbh_pulse u_proc (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .hit_i   (hit_proc),
        .pulse_o (process_command_trigger_o)
    );
    // Pointer write, writes only
    dbh_pulse u_ptr (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .hit_i   (hit_ptr && we_i),
        .pulse_o (pointer_write_strobe_o)
    );
    // Acknowledge, either direction
    dbh_pulse u_ack (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .hit_i   (hit_ptr),
        .pulse_o (interrupt_acknowledge_o)
    );
    // DMA state strobe
    dbh_pulse u_dss (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .hit_i   (hit_dma_state),
        .pulse_o (dma_state_strobe_o)
    );
    // DMA data strobe
    dbh_pulse u_dds (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .hit_i   (hit_dma_data),
        .pulse_o (dma_data_strobe_o)
    );

    // SCSI chip select, register select and write data
    // Select line: 60 low, 62 high
    // Data copied each cycle; cs qualifies it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scsi_cs_o    <= 1'b0;
            scsi_a0_o    <= 1'b0;
            scsi_we_o    <= 1'b0;
            scsi_wdata_o <= 8'h00;
        end else begin
            scsi_cs_o    <= hit_scsi;
            scsi_a0_o    <= hit_scsi_ctrl;
            scsi_we_o    <= hit_scsi && we_i;
            scsi_wdata_o <= wdata_i[7:0];
        end
    end

    // DMA port direction and data
    // One direction for both strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dma_we_o    <= 1'b0;
            dma_wdata_o <= 8'h00;
        end else begin
            dma_we_o    <= hit_dma && we_i;
            dma_wdata_o <= wdata_i[7:0];
        end
    end

    // Control register read image
    // Select, reset and spare bits read zero
    always_comb begin
        status_byte = 8'h00;
        status_byte[dbh_pkg::BIT_INT_ENABLE]  = int_enable_o;
        status_byte[dbh_pkg::BIT_MASTER_RESET] = 1'b0;
        status_byte[dbh_pkg::BIT_CTRL_PTR]    = controller_pointer_flag_q;
        status_byte[dbh_pkg::BIT_INT_PENDING] = interrupt_pending_flag_o;
        status_byte[dbh_pkg::BIT_INTERRUPT_FOLLOW_FLAG]  = interrupt_follow_flag_i;
    end

    // Read data and answer, one cycle after the access
    // Every window hit is acked
    // Strobe-only or unmapped reads return zero
    // Chip data is taken in the access cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 16'h0000;
            ack_o   <= 1'b0;
        end else begin
            ack_o   <= in_board;
            rdata_o <= 16'h0000;
            if (in_board && !we_i) begin
                if (at(offset, dbh_pkg::OFF_CTRL_STATUS)) begin
                    // Control byte on high lanes
                    rdata_o <= {status_byte, 8'h00};
                end else if (offset <= dbh_pkg::OFF_CONFIG_LAST) begin
                    // Identity nybble on top lanes
                    rdata_o <= {cfg_nybble, 12'h000};
                end else if (hit_scsi) begin
                    // SCSI byte on low lanes
                    rdata_o <= {8'h00, scsi_rdata_i};
                end else if (hit_dma) begin
                    // DMA byte on low lanes
                    rdata_o <= {8'h00, dma_rdata_i};
                end
            end
        end
    end
endmodule : dbh_host_io

// >>> dbh_host_io_sva.sv
// Port checker for the host I/O decode, bound to dbh_host_io
module dbh_host_io_chk #(
    parameter int ADDR_W = 24  // Host address width
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [15:0]       wdata_i,
    input wire logic              sel_i,
    input wire logic              we_i,
    input wire logic              int_raise_i,
    input wire logic              config_done_i,
    input wire logic              ack_o,
    input wire logic [7:0]        base_o,
    input wire logic              int_enable_o,
    input wire logic              ctrl_select_o,
    input wire logic              interrupt_pending_flag_o,
    input wire logic              process_command_trigger_o,
    input wire logic              pointer_write_strobe_o,
    input wire logic              interrupt_acknowledge_o,
    input wire logic [15:0]       cmd_ptr_o,
    input wire logic              scsi_cs_o,
    input wire logic              scsi_a0_o,
    input wire logic              scsi_we_o,
    input wire logic              dma_state_strobe_o,
    input wire logic              dma_data_strobe_o
);
    logic       cfg_q;  // Board has been configured
    logic       hit;    // Access falls in the board window
    logic [7:0] off;    // Offset from board base
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Sticky configured marker
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= 1'b0;
        end else if (config_done_i || (hit && we_i && off == 8'h48)) begin
            cfg_q <= 1'b1;
        end
    end
    assign off = addr_i[7:0];
    assign hit = sel_i && (!cfg_q || addr_i[ADDR_W-1:ADDR_W-8] == base_o);
    a_window_ack: assert property (hit |=> ack_o)
        else $error("window access not acknowledged");
    a_miss_no_ack: assert property (!hit |=> !ack_o)
        else $error("acknowledge outside the window");
    a_cmd_trigger: assert property (hit && we_i && off == 8'h50
        |=> process_command_trigger_o == ($past(wdata_i[3:0]) == 4'h1))
        else $error("process trigger wrong");
    a_ptr_load: assert property (hit && we_i && off == 8'h52
        |=> pointer_write_strobe_o && cmd_ptr_o == $past(wdata_i))
        else $error("pointer not latched");
    a_int_ack: assert property (hit && off == 8'h52 && !int_raise_i
        |=> interrupt_acknowledge_o && !interrupt_pending_flag_o)
        else $error("pending not cleared by acknowledge");
    a_scsi_select: assert property (hit && (off == 8'h60 || off == 8'h62)
        |=> scsi_cs_o && scsi_a0_o == $past(addr_i[1]) && scsi_we_o == $past(we_i))
        else $error("SCSI select wrong");
    a_dma_state: assert property (hit && off == 8'h64
        |=> dma_state_strobe_o && !dma_data_strobe_o)
        else $error("DMA state strobe wrong");
    a_dma_data: assert property (hit && off == 8'h68 |=> dma_data_strobe_o)
        else $error("DMA data strobe missing");
    a_ctrl_write: assert property (hit && we_i && off == 8'h40
        |=> ctrl_select_o == $past(wdata_i[9]) && int_enable_o == $past(wdata_i[8]))
        else $error("control write not applied");
    c_trigger: cover property (process_command_trigger_o);
    c_ptr: cover property (pointer_write_strobe_o);
    c_dma: cover property (dma_state_strobe_o ##[1:20] dma_data_strobe_o);
endmodule : dbh_host_io_chk

bind dbh_host_io dbh_host_io_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i, .rst_i, .addr_i, .wdata_i,
    .sel_i, .we_i, .int_raise_i, .config_done_i, .ack_o, .base_o, .int_enable_o, .ctrl_select_o,
    .interrupt_pending_flag_o, .process_command_trigger_o, .pointer_write_strobe_o,
    .interrupt_acknowledge_o, .cmd_ptr_o, .scsi_cs_o, .scsi_a0_o, .scsi_we_o,
    .dma_state_strobe_o, .dma_data_strobe_o);

// >>> dbh_host_bfm.sv
// Host processor model issuing one-cycle accesses
module dbh_host_bfm (
    input  wire logic        clk_i,    // System clock
    input  wire logic        ack_i,    // Access answered
    input  wire logic [15:0] rdata_i,  // Read data
    output logic      [23:0] addr_o,   // Byte address
    output logic      [15:0] wdata_o,  // Write data
    output logic             sel_o,    // Access request
    output logic             we_o      // Write direction
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus at time zero
    initial begin
        addr_o = 24'h000000;
        wdata_o = 16'h0000;
        sel_o = 1'b0;
        we_o = 1'b0;
    end
    // One access, answer taken one cycle later; released lines toggle
    task automatic acc(input logic w, input logic [23:0] a, input logic [15:0] d,
                       output logic [15:0] r, output logic ok);
        @(posedge clk_i);
        #1;
        addr_o = a;
        wdata_o = d;
        we_o = w;
        sel_o = 1'b1;
        @(posedge clk_i);
        #1;
        sel_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
        we_o = ~w;
        ok = ack_i;
        r = rdata_i;
    endtask : acc
endmodule : dbh_host_bfm

// >>> dbh_host_io_tb.sv
// Self-checking bench for the host I/O decode
module dbh_host_io_tb;
    timeunit 1ns;
    timeprecision 100ps;
    `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
        $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
    logic clk_i, rst_i, sel_i, we_i, ctrl_ptr_set_i, ctrl_ptr_clr_i, int_raise_i;
    logic interrupt_follow_flag_i, config_done_i, ack_o, int_enable_o, ctrl_select_o, master_reset_bit_o;
    logic host_pointer_flag_o, interrupt_pending_flag_o, host_int_o, process_command_trigger_o;
    logic pointer_write_strobe_o, interrupt_acknowledge_o, scsi_cs_o, scsi_a0_o, scsi_we_o;
    logic dma_state_strobe_o, dma_data_strobe_o, dma_we_o, ok;
    logic [23:0] addr_i;
    logic [15:0] wdata_i, rdata_o, cmd_ptr_o, r;
    logic [7:0]  scsi_rdata_i, dma_rdata_i, base_o, scsi_wdata_o, dma_wdata_o, hi;
    logic [7:0]  id [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};  // Arbitrary identity values
    int          errors, cmp_count;
    dbh_host_io #(.ADDR_W(24)) dut (.clk_i, .rst_i, .addr_i, .wdata_i, .sel_i, .we_i,
        .ctrl_ptr_set_i, .ctrl_ptr_clr_i, .int_raise_i, .interrupt_follow_flag_i, .config_done_i,
        .scsi_rdata_i, .dma_rdata_i, .rdata_o, .ack_o, .base_o, .int_enable_o, .ctrl_select_o,
        .master_reset_bit_o, .host_pointer_flag_o, .interrupt_pending_flag_o, .host_int_o,
        .process_command_trigger_o, .pointer_write_strobe_o, .interrupt_acknowledge_o,
        .cmd_ptr_o, .scsi_cs_o, .scsi_a0_o, .scsi_we_o, .scsi_wdata_o, .dma_state_strobe_o,
        .dma_data_strobe_o, .dma_we_o, .dma_wdata_o);
    defparam dut.u_rom.BOARD_TYPE = 8'hA5;
    defparam dut.u_rom.PRODUCT    = 8'h5A;
    defparam dut.u_rom.MAKER_HIGH = 8'h3C;
    defparam dut.u_rom.MAKER_LOW  = 8'hC3;
    dbh_host_bfm host (.clk_i, .ack_i(ack_o), .rdata_i(rdata_o), .addr_o(addr_i),
        .wdata_o(wdata_i), .sel_o(sel_i), .we_o(we_i));
    // Access at an offset under the top address byte held in hi
    task automatic io(input logic w, input logic [7:0] o, input logic [15:0] d);
        host.acc(w, {hi, 8'h00, o}, d, r, ok);
    endtask : io
    // One-cycle pulse on the onboard controller inputs
    task automatic pulse(input logic s, input logic c, input logic i);
        ctrl_ptr_set_i = s;
        ctrl_ptr_clr_i = c;
        int_raise_i = i;
        @(posedge clk_i);
        #1;
        {ctrl_ptr_set_i, ctrl_ptr_clr_i, int_raise_i} = 3'b000;
    endtask : pulse
    // Summary and verdict
    task automatic stop_test;
        $display("Comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    // Free-running clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Guard against a hang
    initial begin
        #100000;
        errors++;
        stop_test();
    end
    // Main sequence
    initial begin
        {rst_i, ctrl_ptr_set_i, ctrl_ptr_clr_i, int_raise_i} = 4'hF;
        {interrupt_follow_flag_i, config_done_i, hi} = 10'h000;
        scsi_rdata_i = 8'h5C;
        dma_rdata_i = 8'hA3;
        repeat (3) @(posedge clk_i);
        #1;
        {rst_i, ctrl_ptr_set_i, ctrl_ptr_clr_i, int_raise_i} = 4'h0;
        `CHK({base_o, cmd_ptr_o}, {dbh_pkg::BASE_RESET, dbh_pkg::PTR_RESET});
        `CHK({ack_o, host_int_o, scsi_cs_o, dma_state_strobe_o}, 4'h0);
        for (int i = 0; i < 8; i++) begin
            io(1'b0, {3'b000, i[2], 1'b0, i[1], i[0], 1'b0}, 16'h0000);
            `CHK(r[15:12], i[0] ? id[i / 2][3:0] : id[i / 2][7:4]);
        end
        io(1'b1, 8'h48, 16'hE000);
        `CHK(base_o, 8'hE0);
        config_done_i = 1'b1;
        hi = 8'hE1;
        io(1'b0, 8'h40, 16'h0000);
        `CHK(ok, 1'b0);
        hi = 8'hE0;
        io(1'b1, 8'h40, 16'h0B00);
        `CHK({host_pointer_flag_o, master_reset_bit_o, ctrl_select_o, int_enable_o}, 4'hB);
        io(1'b1, 8'h40, 16'h0400);
        `CHK({master_reset_bit_o, ctrl_select_o}, 2'b10);
        io(1'b1, 8'h40, 16'h0100);
        interrupt_follow_flag_i = 1'b1;
        pulse(1'b1, 1'b0, 1'b1);
        io(1'b0, 8'h40, 16'h0000);
        `CHK(r[15:8], 8'h99);
        `CHK(host_int_o, 1'b1);
        pulse(1'b0, 1'b1, 1'b0);
        io(1'b0, 8'h40, 16'h0000);
        `CHK(r[15:8], 8'h91);
        io(1'b1, 8'h50, 16'h0001);
        `CHK(process_command_trigger_o, 1'b1);
        io(1'b1, 8'h50, 16'h00A2);
        `CHK({ok, process_command_trigger_o}, 2'b10);
        io(1'b1, 8'h52, 16'hBEEF);
        `CHK({pointer_write_strobe_o, interrupt_acknowledge_o, cmd_ptr_o}, {2'b11, 16'hBEEF});
        `CHK(interrupt_pending_flag_o, 1'b0);
        io(1'b0, 8'h52, 16'h1234);
        `CHK({pointer_write_strobe_o, interrupt_acknowledge_o, cmd_ptr_o}, {2'b01, 16'hBEEF});
        io(1'b1, 8'h60, 16'h0033);
        `CHK({scsi_cs_o, scsi_a0_o, scsi_we_o, scsi_wdata_o}, {3'b101, 8'h33});
        io(1'b0, 8'h62, 16'h0000);
        `CHK({scsi_cs_o, scsi_a0_o, scsi_we_o, r[7:0]}, {3'b110, 8'h5C});
        io(1'b1, 8'h64, 16'h00FB);
        `CHK({dma_state_strobe_o, dma_data_strobe_o, dma_we_o, dma_wdata_o}, {3'b101, 8'hFB});
        io(1'b1, 8'h68, 16'h0077);
        `CHK({dma_state_strobe_o, dma_data_strobe_o, dma_we_o, dma_wdata_o}, {3'b011, 8'h77});
        io(1'b0, 8'h68, 16'h0000);
        `CHK({dma_data_strobe_o, dma_we_o, r[7:0]}, {2'b10, 8'hA3});
        io(1'b0, 8'h58, 16'h0000);
        `CHK({ok, r}, {1'b1, 16'h0000});
        rst_i = 1'b1;
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        `CHK({base_o, cmd_ptr_o}, {dbh_pkg::BASE_RESET, dbh_pkg::PTR_RESET});
        `CHK({int_enable_o, ack_o}, 2'b00);
        hi = 8'h00;
        io(1'b0, 8'h40, 16'h0000);
        `CHK({ok, r[15:8]}, {1'b1, 8'h80});
        stop_test();
    end
endmodule : dbh_host_io_tb
